/* hw/vrs_pkg.sv */
// package: constants, register map and state types of the reference sequencer
package vrs_pkg;
    // levels in units of 0.125 mV
    localparam logic [15:0] STEP8 = 16'h0032;      // 6.25 mV
    localparam logic [15:0] STEP6 = 16'h00c8;      // 25 mV
    localparam logic [15:0] SS6_STEP = 16'h0019;   // 3.125 mV per switching cycle
    localparam logic [15:0] OFS8 = 16'h0098;       // 19 mV
    localparam logic [15:0] TOP8 = 16'h3200;       // 1.600 V at code 0
    localparam logic [15:0] TOP6 = 16'h3070;       // 1.550 V at code 0
    localparam logic [15:0] BOOT8 = 16'h21c8;      // 1.081 V
    localparam logic [15:0] UV_EN = 16'h12c0;      // 0.6 V
    localparam logic [15:0] OV8_PRE = 16'h26c0;    // 1.24 V
    localparam logic [15:0] OV6 = 16'h3840;        // 1.800 V
    localparam logic [15:0] OV_MARGIN = 16'h04b0;  // code-derived trip margin
    // timing
    localparam int CLK_KHZ = 10000;
    localparam int T1_US = 1000;
    localparam int T3_US = 75;
    localparam int DV8_KHZ = 1000;
    localparam int DV6_KHZ = 250;
    localparam int T1_CYC = T1_US * CLK_KHZ / 1000;
    localparam logic [15:0] T3_CYC = 16'(T3_US * CLK_KHZ / 1000);
    localparam logic [7:0] HALF8 = 8'(CLK_KHZ / (2 * DV8_KHZ));
    localparam logic [7:0] HALF6 = 8'(CLK_KHZ / (2 * DV6_KHZ));
    localparam logic [5:0] MASK_CYC = 6'h20;       // 32 switching cycles
    // register map
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_SOFTSTART_OSC_SETTING = 8'h04;
    localparam logic [7:0] A_MAINOSC = 8'h08;
    localparam logic [7:0] A_OVPPROG = 8'h0c;
    localparam logic [7:0] A_STATUS = 8'h10;
    localparam logic [7:0] A_REF = 8'h14;
    localparam logic [7:0] A_CODE = 8'h18;
    localparam logic [15:0] SOFTSTART_OSC_SETTING_RST = 16'h0064;
    localparam logic [15:0] MAINOSC_RST = 16'h0043;
    localparam logic [1:0] MODE_8A = 2'h0;
    localparam logic [1:0] MODE_6 = 2'h2;

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_SS_DLY = 3'b001,
        ST_SS_BOOT = 3'b010,
        ST_SS_READ = 3'b011,
        ST_SS_RAMP = 3'b100,
        ST_RUN = 3'b101,
        ST_FAULT = 3'b110
    } vrs_state_t;

    typedef enum logic [1:0] {
        DV_IDLE = 2'b00,
        DV_CONF = 2'b01,
        DV_ARM = 2'b10,
        DV_STEP = 2'b11
    } vrs_dv_t;

    typedef struct packed {
        logic [1:0] en_s;
        logic [1:0] vcc_s;
        logic [1:0] vdr_s;
        logic [1:0] ov_s;
        logic [1:0] uv_s;
        logic [1:0] pg_s;
        logic [7:0] code_s1;
        logic [7:0] code_s2;
        vrs_state_t st;
        vrs_dv_t dv;
        logic [31:0] dly;
        logic [15:0] ref_lvl;
        logic [15:0] tgt;
        logic boot_done;
        logic [7:0] code_acc;
        logic [7:0] code_cand;
        logic [5:0] mask_cnt;
        logic [7:0] cs_cnt;
        logic cs_clk;
        logic [15:0] ss_cnt;
        logic [15:0] mo_cnt;
        logic ov_f;
        logic uv_f;
        logic drv_en;
        logic ls_force;
        logic good;
        logic flag;
        logic [15:0] ovp_lvl;
        logic [1:0] mode;
        logic ovp_prog_en;
        logic [15:0] ss_div;
        logic [15:0] mo_div;
        logic [15:0] ovp_prog;
        logic ah_wr;
        logic [7:0] ah_addr;
        logic [31:0] hrdata;
        logic hready;
    } vrs_regs_t;
endpackage

/* hw/vrs_sequencer.sv */
// reference sequencer: enable, soft-start, code transitions, protection masking, bus slave
// Contract
// - mask trips and good 32 cycles after transition
// - detect code on rise, confirm on fall
// - step one LSB per code-step clock
// - LSB is 6.25mV or 25mV by mode
// - ignore code during transition, resume after
// - code-step clock 1MHz or 250kHz by mode
// - 6-bit mode flag high through transition
// - low supplies keep device shut down
// - soft-start only with supplies and enable
// - enable low clears faults, disables, good low
// - release good when soft-start ramp ends
// - OV always on, UV from 0.6V; code disables OV during transitions, their mask, off and fault
// - 8-bit: delay, boot ramp, pause, ramp
// - 8-bit soft-start timed by soft-start oscillator
// - 8-bit OV 1.24V until boot reached
// - code below boot ramps downward
// - 6-bit: zero to code on switching clock
// - 6-bit OV 1.8V or programmed threshold
// - reference is table minus 19mV or exact
//
// Design decisions made here: register access over AHB-Lite and the address map.
module vrs_sequencer #(
    parameter int T1_CYCLES = vrs_pkg::T1_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic output_enable_pin,
    input wire logic control_supply_ok,
    input wire logic lowside_driver_supply_ok,
    input wire logic [7:0] voltage_id_code,
    input wire logic overvoltage_cmp,
    input wire logic undervoltage_cmp,
    input wire logic power_low_cmp,
    output logic [15:0] ref_level,
    output logic [15:0] ovp_level,
    output logic drivers_enable,
    output logic lowside_force_on,
    output logic overvoltage_trip,
    output logic undervoltage_trip,
    output logic startup_done_good_out,
    output logic transition_flag_out
);
    vrs_pkg::vrs_regs_t q, d;
    logic mode6, cs_rise, cs_fall, ss_tick, mo_tick, masking, ov_on, uv_on, busy;
    logic [7:0] half;
    logic [15:0] lsb, nref;

    // table voltage of a code as an internal reference level
    function automatic logic [15:0] lvl(input logic [7:0] c, input logic six);
        logic [15:0] p;
        p = 16'h0000;
        if (six) begin
            p = 16'(c[5:0]) * vrs_pkg::STEP6;
            lvl = (p > vrs_pkg::TOP6) ? 16'h0000 : 16'(vrs_pkg::TOP6 - p);
        end else begin
            p = 16'(16'(c) * vrs_pkg::STEP8) + vrs_pkg::OFS8;
            lvl = (p > vrs_pkg::TOP8) ? 16'h0000 : 16'(vrs_pkg::TOP8 - p);
        end
    endfunction

    // one step of r toward t, never past it
    function automatic logic [15:0] step_to(input logic [15:0] r, input logic [15:0] t,
                                            input logic [15:0] s);
        step_to = r;
        if (r < t) begin
            step_to = (t - r > s) ? 16'(r + s) : t;
        end else if (r > t) begin
            step_to = (r - t > s) ? 16'(r - s) : t;
        end
    endfunction

    always_comb begin
        mode6 = (q.mode == vrs_pkg::MODE_6);
        half = mode6 ? vrs_pkg::HALF6 : vrs_pkg::HALF8;
        cs_rise = (q.cs_cnt >= 8'(half - 8'h01)) && !q.cs_clk;
        cs_fall = (q.cs_cnt >= 8'(half - 8'h01)) && q.cs_clk;
        ss_tick = (q.ss_cnt >= q.ss_div);
        mo_tick = (q.mo_cnt >= q.mo_div);
        lsb = mode6 ? vrs_pkg::STEP6 : vrs_pkg::STEP8;
        busy = (q.dv == vrs_pkg::DV_ARM) || (q.dv == vrs_pkg::DV_STEP);
        masking = busy || (q.mask_cnt != 6'h00);
        ov_on = (q.st != vrs_pkg::ST_OFF) && (q.st != vrs_pkg::ST_FAULT) && !masking;
        uv_on = ov_on && (q.ref_lvl >= vrs_pkg::UV_EN);
        nref = step_to(q.ref_lvl, q.tgt, lsb);

        d = q;
        // two-stage synchronisers for pins
        d.en_s = {q.en_s[0], output_enable_pin};
        d.vcc_s = {q.vcc_s[0], control_supply_ok};
        d.vdr_s = {q.vdr_s[0], lowside_driver_supply_ok};
        d.ov_s = {q.ov_s[0], overvoltage_cmp};
        d.uv_s = {q.uv_s[0], undervoltage_cmp};
        d.pg_s = {q.pg_s[0], power_low_cmp};
        d.code_s1 = voltage_id_code;
        d.code_s2 = q.code_s1;

        // free-running clocks
        d.cs_cnt = cs_rise || cs_fall ? 8'h00 : 8'(q.cs_cnt + 8'h01);
        if (cs_rise || cs_fall) begin
            d.cs_clk = !q.cs_clk;
        end
        d.ss_cnt = ss_tick ? 16'h0000 : 16'(q.ss_cnt + 16'h0001);
        d.mo_cnt = mo_tick ? 16'h0000 : 16'(q.mo_cnt + 16'h0001);
        if (mo_tick && q.mask_cnt != 6'h00) begin
            d.mask_cnt = 6'(q.mask_cnt - 6'h01);
        end

        case (q.st)
            vrs_pkg::ST_OFF: begin
                d.ref_lvl = 16'h0000;
                d.boot_done = 1'b0;
                d.dv = vrs_pkg::DV_IDLE;
                d.mask_cnt = 6'h00;
                d.dly = 32'h0;
                if (mode6) begin
                    d.tgt = lvl(q.code_s2, 1'b1);
                    d.code_acc = q.code_s2;
                    d.st = vrs_pkg::ST_SS_RAMP;
                end else begin
                    d.st = vrs_pkg::ST_SS_DLY;
                end
            end
            vrs_pkg::ST_SS_DLY: begin
                d.dly = 32'(q.dly + 32'h1);
                if (q.dly >= 32'(T1_CYCLES - 1)) begin
                    d.tgt = vrs_pkg::BOOT8;
                    d.st = vrs_pkg::ST_SS_BOOT;
                end
            end
            vrs_pkg::ST_SS_BOOT: begin
                if (ss_tick) begin
                    d.ref_lvl = step_to(q.ref_lvl, vrs_pkg::BOOT8, vrs_pkg::STEP8);
                end
                if (q.ref_lvl == vrs_pkg::BOOT8) begin
                    d.boot_done = 1'b1;
                    d.dly = 32'h0;
                    d.st = vrs_pkg::ST_SS_READ;
                end
            end
            vrs_pkg::ST_SS_READ: begin
                d.dly = 32'(q.dly + 32'h1);
                if (q.dly >= 32'(vrs_pkg::T3_CYC - 16'h0001)) begin
                    d.code_acc = q.code_s2;
                    d.tgt = lvl(q.code_s2, 1'b0);
                    d.st = vrs_pkg::ST_SS_RAMP;
                end
            end
            vrs_pkg::ST_SS_RAMP: begin
                if (mode6 && mo_tick) begin
                    d.ref_lvl = step_to(q.ref_lvl, q.tgt, vrs_pkg::SS6_STEP);
                end else if (!mode6 && ss_tick) begin
                    d.ref_lvl = step_to(q.ref_lvl, q.tgt, vrs_pkg::STEP8);
                end
                if (q.ref_lvl == q.tgt) begin
                    d.st = vrs_pkg::ST_RUN;
                end
            end
            vrs_pkg::ST_RUN: begin
                case (q.dv)
                    vrs_pkg::DV_IDLE: begin
                        if (cs_rise && q.code_s2 != q.code_acc) begin
                            d.code_cand = q.code_s2;
                            d.dv = vrs_pkg::DV_CONF;
                        end
                    end
                    vrs_pkg::DV_CONF: begin
                        if (cs_fall) begin
                            d.dv = (q.code_s2 == q.code_cand) ? vrs_pkg::DV_ARM
                                                              : vrs_pkg::DV_IDLE;
                        end
                    end
                    vrs_pkg::DV_ARM: begin
                        if (cs_rise) begin
                            d.code_acc = q.code_cand;
                            d.tgt = lvl(q.code_cand, mode6);
                            d.ref_lvl = step_to(q.ref_lvl, lvl(q.code_cand, mode6), lsb);
                            d.dv = vrs_pkg::DV_STEP;
                        end
                    end
                    default: begin
                        // code lines are not looked at while stepping
                        if (q.ref_lvl == q.tgt) begin
                            d.dv = vrs_pkg::DV_IDLE;
                            d.mask_cnt = vrs_pkg::MASK_CYC;
                        end else if (cs_rise) begin
                            d.ref_lvl = nref;
                        end
                    end
                endcase
            end
            default: begin
                d.st = vrs_pkg::ST_FAULT;
            end
        endcase

        // latched protections
        if (ov_on && q.ov_s[1]) begin
            d.ov_f = 1'b1;
            d.st = vrs_pkg::ST_FAULT;
        end
        if (uv_on && q.uv_s[1]) begin
            d.uv_f = 1'b1;
            d.st = vrs_pkg::ST_FAULT;
        end
        if (!q.vcc_s[1] || !q.vdr_s[1]) begin
            d.st = vrs_pkg::ST_OFF;
            d.dly = 32'h0;
        end
        if (!q.en_s[1]) begin
            d.st = vrs_pkg::ST_OFF;
            d.ov_f = 1'b0;
            d.uv_f = 1'b0;
            d.dly = 32'h0;
        end
        if (d.st == vrs_pkg::ST_OFF && q.st == vrs_pkg::ST_OFF && !q.en_s[1]) begin
            d.st = vrs_pkg::ST_OFF;
        end else if (q.st == vrs_pkg::ST_OFF && (!q.en_s[1] || !q.vcc_s[1] || !q.vdr_s[1])) begin
            d.st = vrs_pkg::ST_OFF;
        end

        // registered pin outputs
        d.drv_en = (q.st != vrs_pkg::ST_OFF) && (q.st != vrs_pkg::ST_FAULT)
                   && (d.st != vrs_pkg::ST_OFF) && (d.st != vrs_pkg::ST_FAULT);
        d.ls_force = d.ov_f && q.vcc_s[1] && q.vdr_s[1] && q.en_s[1];
        d.good = (d.st == vrs_pkg::ST_RUN) && q.en_s[1]
                 && !(mode6 && q.pg_s[1] && !masking);
        d.flag = mode6 && (q.st == vrs_pkg::ST_RUN) && (d.dv == vrs_pkg::DV_ARM
                 || d.dv == vrs_pkg::DV_STEP || d.mask_cnt != 6'h00);
        if (mode6) begin
            d.ovp_lvl = q.ovp_prog_en ? q.ovp_prog : vrs_pkg::OV6;
        end else if (!q.boot_done) begin
            d.ovp_lvl = vrs_pkg::OV8_PRE;
        end else begin
            d.ovp_lvl = q.ovp_prog_en ? q.ovp_prog : 16'(q.tgt + vrs_pkg::OV_MARGIN);
        end

        // bus slave: address phase captured, data phase answered with no wait
        d.hready = 1'b1;
        d.ah_wr = hsel && hready && htrans[1] && hwrite;
        d.ah_addr = haddr[7:0];
        if (q.ah_wr) begin
            if (q.ah_addr == vrs_pkg::A_CTRL) begin
                d.mode = hwdata[1:0];
                d.ovp_prog_en = hwdata[2];
            end else if (q.ah_addr == vrs_pkg::A_SOFTSTART_OSC_SETTING) begin
                d.ss_div = hwdata[15:0];
            end else if (q.ah_addr == vrs_pkg::A_MAINOSC) begin
                d.mo_div = hwdata[15:0];
            end else if (q.ah_addr == vrs_pkg::A_OVPPROG) begin
                d.ovp_prog = hwdata[15:0];
            end
        end
        d.hrdata = 32'h0;
        if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr[7:0] == vrs_pkg::A_CTRL) begin
                d.hrdata = {29'h0, q.ovp_prog_en, q.mode};
            end else if (haddr[7:0] == vrs_pkg::A_SOFTSTART_OSC_SETTING) begin
                d.hrdata = {16'h0, q.ss_div};
            end else if (haddr[7:0] == vrs_pkg::A_MAINOSC) begin
                d.hrdata = {16'h0, q.mo_div};
            end else if (haddr[7:0] == vrs_pkg::A_OVPPROG) begin
                d.hrdata = {16'h0, q.ovp_prog};
            end else if (haddr[7:0] == vrs_pkg::A_STATUS) begin
                d.hrdata = {20'h0, q.flag, q.good, q.uv_f, q.ov_f, q.boot_done, masking,
                            q.dv, 1'b0, q.st};
            end else if (haddr[7:0] == vrs_pkg::A_REF) begin
                d.hrdata = {16'h0, q.ref_lvl};
            end else if (haddr[7:0] == vrs_pkg::A_CODE) begin
                d.hrdata = {24'h0, q.code_acc};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
            q.st <= vrs_pkg::ST_OFF;
            q.dv <= vrs_pkg::DV_IDLE;
            q.mode <= vrs_pkg::MODE_8A;
            q.ss_div <= vrs_pkg::SOFTSTART_OSC_SETTING_RST;
            q.mo_div <= vrs_pkg::MAINOSC_RST;
            q.ovp_lvl <= vrs_pkg::OV8_PRE;
            q.hready <= 1'b1;
        end else if (ce) begin
            q <= d;
        end
    end

    assign hreadyout = q.hready;
    assign hresp = 1'b0;
    assign hrdata = q.hrdata;
    assign ref_level = q.ref_lvl;
    assign ovp_level = q.ovp_lvl;
    assign drivers_enable = q.drv_en;
    assign lowside_force_on = q.ls_force;
    assign overvoltage_trip = q.ov_f;
    assign undervoltage_trip = q.uv_f;
    assign startup_done_good_out = q.good;
    assign transition_flag_out = q.flag;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n || !ce);

    sequence s_confirmed;
        q.dv == vrs_pkg::DV_CONF ##1 q.dv == vrs_pkg::DV_ARM;
    endsequence

    a_mask_trips: assert property (q.mask_cnt != 6'h00 |-> !ov_on && !uv_on)
        else $error("trips enabled during trailing mask");
    a_confirm_fall: assert property (s_confirmed |-> $past(cs_fall))
        else $error("code accepted without falling-edge confirm");
    a_step_lsb: assert property (q.st == vrs_pkg::ST_RUN && $past(q.st) == vrs_pkg::ST_RUN
        && $changed(q.ref_lvl) |-> (q.ref_lvl - $past(q.ref_lvl) == $past(lsb))
        || ($past(q.ref_lvl) - q.ref_lvl == $past(lsb)) || q.ref_lvl == q.tgt)
        else $error("reference step not one lsb");
    a_step_ignore: assert property (q.dv == vrs_pkg::DV_STEP && $past(q.dv) == vrs_pkg::DV_STEP
        |-> q.code_acc == $past(q.code_acc) && q.tgt == $past(q.tgt))
        else $error("code change taken during transition");
    a_flag_span: assert property (q.mode == vrs_pkg::MODE_6 && q.st == vrs_pkg::ST_RUN
        && q.mask_cnt > 6'h01 |=> q.flag)
        else $error("transition flag low during masking");
    a_supply_off: assert property (!q.vcc_s[1] |=> !q.drv_en && q.st == vrs_pkg::ST_OFF)
        else $error("driver enabled with supply low");
    a_enable_low: assert property (!q.en_s[1] |=> !q.good && !q.ov_f && !q.uv_f && !q.drv_en)
        else $error("enable low did not clear and disable");
    a_good_end: assert property ($rose(q.good) |-> q.st == vrs_pkg::ST_RUN
        && q.ref_lvl == q.tgt)
        else $error("good released before ramp end");
    a_uv_gate: assert property (q.ref_lvl < vrs_pkg::UV_EN |-> !uv_on)
        else $error("undervoltage armed below 0.6V");
    a_boot_ovp: assert property (q.st == vrs_pkg::ST_SS_BOOT && $past(q.st) == vrs_pkg::ST_SS_BOOT
        && q.mode != vrs_pkg::MODE_6 |-> q.ovp_lvl == vrs_pkg::OV8_PRE)
        else $error("pre-boot overvoltage level wrong");
    a_six_ovp: assert property (q.mode == vrs_pkg::MODE_6 && !q.ovp_prog_en
        && $past(q.mode) == vrs_pkg::MODE_6 && !$past(q.ovp_prog_en)
        |-> q.ovp_lvl == vrs_pkg::OV6)
        else $error("6-bit overvoltage level wrong");
endmodule

/* test/tb_top.sv */
// testbench: bus access, soft-start in both table modes, code transitions, faults
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, en = 1'b0;
    logic vcc_ok = 1'b0, vdr_ok = 1'b0, ov_c = 1'b0, uv_c = 1'b0, pl_c = 1'b0, watch = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
    logic hreadyout, hresp, drv_en, ls_on, ov_t, uv_t, good, flag;
    logic [7:0] want = 8'h00, code;
    logic [15:0] ref_level, ovp_level, prev_ref;
    int bad_count = 0, tests_run = 0, cyc = 0, step = 0, d, c;

    vrs_code_source #(.GAP(1)) vrs_code_source_i (.clk(clk), .want(want), .voltage_id_code(code));
    vrs_sequencer #(.T1_CYCLES(50)) vrs_sequencer_i (
        .clk(clk), .reset_n(reset_n), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .output_enable_pin(en),
        .control_supply_ok(vcc_ok), .lowside_driver_supply_ok(vdr_ok), .voltage_id_code(code),
        .overvoltage_cmp(ov_c), .undervoltage_cmp(uv_c), .power_low_cmp(pl_c),
        .ref_level(ref_level), .ovp_level(ovp_level), .drivers_enable(drv_en),
        .lowside_force_on(ls_on), .overvoltage_trip(ov_t), .undervoltage_trip(uv_t),
        .startup_done_good_out(good), .transition_flag_out(flag));

    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    // reference moves exactly one table step per change while a transition runs
    always @(negedge clk) begin
        if (watch && ref_level !== prev_ref) begin
            d = int'(ref_level) - int'(prev_ref);
            check("ref step", step, d < 0 ? -d : d);
        end
        prev_ref = ref_level;
    end

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        v = hrdata;
        check("hresp", 32'h0, hresp);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
        bus(1'b0, a, 32'h0);
        check(what, e, v);
    endtask

    function automatic int exp_ref(int cd, bit six);
        int r;
        r = six ? int'(vrs_pkg::TOP6) - (cd % 64) * int'(vrs_pkg::STEP6)
            : int'(vrs_pkg::TOP8) - cd * int'(vrs_pkg::STEP8) - int'(vrs_pkg::OFS8);
        return r < 0 ? 0 : r;
    endfunction

    task automatic wait_ref(input int e);
        while (ref_level !== 16'(e)) @(negedge clk);
    endtask

    task automatic set_code(input logic [7:0] cd);
        @(posedge clk);
        want <= cd;
        while (code !== cd) @(negedge clk);
        @(posedge clk);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        c = $urandom(87);
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check("hreadyout", 32'h1, hreadyout);
        check("ovp reset", 32'(vrs_pkg::OV8_PRE), ovp_level);
        rd_chk(vrs_pkg::A_SOFTSTART_OSC_SETTING, 32'(vrs_pkg::SOFTSTART_OSC_SETTING_RST), "ss divider");
        rd_chk(vrs_pkg::A_MAINOSC, 32'(vrs_pkg::MAINOSC_RST), "main divider");
        rd_chk(8'h40, 32'h0, "unmapped");
        bus(1'b1, vrs_pkg::A_CTRL, 32'(vrs_pkg::MODE_6));
        rd_chk(vrs_pkg::A_CTRL, 32'h2, "ctrl");
        bus(1'b1, vrs_pkg::A_MAINOSC, 32'h3);
        bus(1'b1, vrs_pkg::A_REF, 32'h1234);
        rd_chk(vrs_pkg::A_REF, 32'h0, "ref read only");
        set_code(8'h10);
        en <= 1'b1;
        vcc_ok <= 1'b1;
        repeat (200) @(negedge clk);
        check("drivers low supply", 32'h0, drv_en);
        check("good low supply", 32'h0, good);
        @(posedge clk);
        vdr_ok <= 1'b1;
        while (ref_level === 16'h0) @(negedge clk);
        check("ovp 6 soft-start", 32'(vrs_pkg::OV6), ovp_level);
        check("drivers run", 32'h1, drv_en);
        while (good !== 1'b1) @(negedge clk);
        check("ref 6 start", exp_ref(8'h10, 1'b1), ref_level);
        step = int'(vrs_pkg::STEP6);
        watch = 1'b1;
        @(posedge clk);
        want <= 8'h14;
        while (flag !== 1'b1) @(negedge clk);
        @(posedge clk);
        want <= 8'h10;
        uv_c <= 1'b1;
        pl_c <= 1'b1;
        wait_ref(exp_ref(8'h14, 1'b1));
        check("flag in step", 32'h1, flag);
        check("good masked", 32'h1, good);
        @(posedge clk);
        uv_c <= 1'b0;
        pl_c <= 1'b0;
        wait_ref(exp_ref(8'h10, 1'b1));
        while (flag !== 1'b0) @(negedge clk);
        check("uv masked", 32'h0, uv_t);
        check("ref after ignore", exp_ref(8'h10, 1'b1), ref_level);
        watch = 1'b0;
        @(posedge clk);
        pl_c <= 1'b1;
        repeat (4) @(negedge clk);
        check("good unmasked", 32'h0, good);
        @(posedge clk);
        pl_c <= 1'b0;
        repeat (4) @(negedge clk);
        check("good back", 32'h1, good);
        rd_chk(vrs_pkg::A_CODE, 32'h10, "code");
        bus(1'b1, vrs_pkg::A_OVPPROG, 32'h3000);
        bus(1'b1, vrs_pkg::A_CTRL, 32'h6);
        repeat (2) @(negedge clk);
        check("ovp programmed", 32'h3000, ovp_level);
        bus(1'b1, vrs_pkg::A_CTRL, 32'(vrs_pkg::MODE_6));
        @(posedge clk);
        ov_c <= 1'b1;
        while (ov_t !== 1'b1) @(negedge clk);
        check("lowside on", 32'h1, ls_on);
        check("drivers ov", 32'h0, drv_en);
        @(posedge clk);
        ov_c <= 1'b0;
        en <= 1'b0;
        while (ov_t !== 1'b0) @(negedge clk);
        check("good off", 32'h0, good);
        check("drivers off", 32'h0, drv_en);
        bus(1'b1, vrs_pkg::A_CTRL, 32'(vrs_pkg::MODE_8A));
        bus(1'b1, vrs_pkg::A_SOFTSTART_OSC_SETTING, 32'h1);
        for (int i = 0; i < 2; i++) begin
            c = (i == 0) ? 16 : $urandom_range(8, 247);
            set_code(8'(c));
            en <= 1'b1;
            while (ref_level === 16'h0) @(negedge clk);
            check("ovp 8 pre", 32'(vrs_pkg::OV8_PRE), ovp_level);
            while (good !== 1'b1) @(negedge clk);
            check("ref 8 start", exp_ref(c, 1'b0), ref_level);
            if (i == 0) begin
                @(posedge clk);
                en <= 1'b0;
                while (good !== 1'b0) @(negedge clk);
            end
        end
        step = int'(vrs_pkg::STEP8);
        watch = 1'b1;
        @(posedge clk);
        want <= 8'(c - 3);
        wait_ref(exp_ref(c - 3, 1'b0));
        check("flag 8-bit", 32'h0, flag);
        repeat (400) @(negedge clk);
        check("ref 8 step", exp_ref(c - 3, 1'b0), ref_level);
        watch = 1'b0;
        end_of_test();
    end
endmodule

/* test/vrs_code_source.sv */
// code-line source: processor side driving the voltage code lines
module vrs_code_source #(
    parameter int GAP = 16
) (
    input wire logic clk,
    input wire logic [7:0] want,
    output logic [7:0] voltage_id_code
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    logic [7:0] code_q = 8'h00;
    assign voltage_id_code = code_q;
    // one code step per GAP cycles keeps the output slope bounded
    always @(posedge clk) begin
        cnt <= (cnt >= GAP - 1) ? 0 : cnt + 1;
        if (cnt == 0 && code_q < want) begin
            code_q <= code_q + 8'h01;
        end else if (cnt == 0 && code_q > want) begin
            code_q <= code_q - 8'h01;
        end
    end
endmodule
